// *** design/sed_top.sv ***
// secondary encoder input decoder: edge counting, 120 us sampling, scaling with
// fractional and excess carry, index capture and dual-loop feedback selection
// assumes synchronous pin inputs, one 10 MHz clock and an Avalon-MM master
`timescale 1ns/1ns

// How it works
// RULE1: count decoded edges, sample every 120 us
// RULE2: scale counts, add fraction, apply whole part
// RULE3: keep leftover fraction for next period
// RULE4: clamp applied counts, carry excess forward
// RULE5: source keeps speed at most 4000 RPM
// RULE6: step input rising edge gives one count
// RULE7: direction level chooses counting direction
// RULE8: up pulses add, down pulses subtract
// RULE9: quadrature counts every edge of both
// RULE10: phase lead decides quadrature direction
// RULE11: index pulse accepted beside count channels
// RULE12: variant offers three or two formats
// RULE13: dual loop feeds external count as position
// RULE14: internal position still drives commutation, estimation
// RULE15: dual enable only after input configured (the code skips this check when the serial source is set)
// RULE16: single loop restores internal feedback everywhere
// RULE17: serial source chosen first feeds dual loop
// RULE18: serial dual loop leaves pulse input commanding
// RULE19: ignore double changes, A leading counts up
module sed_top #(
    parameter bit THREE_FORMATS = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [sed_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_index_i,
    input wire logic [31:0] int_pos_i,
    input wire logic [31:0] serial_pos_i,
    output logic [31:0] loop_pos_o,
    output logic [31:0] commut_pos_o,
    output logic [31:0] est_pos_o,
    output logic [31:0] motion_cmd_pos_o,
    output logic motion_cmd_en_o,
    output logic sample_tick_o
);
    import sed_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    sed_fmt_type fmt_ff;
    sed_loop_type loop_ff;
    sed_loop_type nxt_loop;
    logic configured_ff;
    logic serial_src_ff;
    logic index_flag_ff;
    logic index_prev_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [15:0] scale_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic signed [15:0] raw_ff;
    logic [7:0] frac_ff;
    logic signed [23:0] excess_ff;
    logic [31:0] ext_pos_ff;
    logic [31:0] index_pos_ff;
    logic [31:0] loop_pos_ff;
    logic [31:0] commut_pos_ff;
    logic [31:0] est_pos_ff;
    logic sample_ff;
    logic cnt_up;
    logic cnt_dn;

    // clamp a whole count into the per-period window
    function automatic logic signed [31:0] sed_clamp(input logic signed [31:0] v);
        if (v > APPLY_MAX) begin
            sed_clamp = APPLY_MAX;
        end else if (v < APPLY_MIN) begin
            sed_clamp = APPLY_MIN;
        end else begin
            sed_clamp = v;
        end
    endfunction

    // ****************************************
    // edge decoding
    // ****************************************
    sed_edge_decoder u_dec (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .fmt_i(fmt_ff),
        .ch_a_i(enc_a_i),
        .ch_b_i(enc_b_i),
        .cnt_up_o(cnt_up),
        .cnt_dn_o(cnt_dn)
    );

    // ****************************************
    // avalon slave decode
    // ****************************************
    // one wait cycle per access; the ack flop also blocks a repeat action
    wire bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_ff;
    wire wr_en = avs_write_i & ack_ff;
    wire wr_format = wr_en & (avs_address_i == ADDR_FORMAT) & avs_byteenable_i[0];
    wire wr_command = wr_en & (avs_address_i == ADDR_COMMAND) & avs_byteenable_i[0];
    wire wr_scale = wr_en & (avs_address_i == ADDR_SCALE);
    wire wr_status = wr_en & (avs_address_i == ADDR_STATUS) & avs_byteenable_i[0];
    wire [7:0] cmd_code = avs_writedata_i[7:0];
    wire [1:0] fmt_req = avs_writedata_i[1:0];
    // the two-format variant refuses up/down and any unused code
    wire fmt_legal = (fmt_req == FMT_STEP_DIR) | (fmt_req == FMT_QUAD)
                     | ((fmt_req == FMT_UP_DOWN) & THREE_FORMATS); // RULE12
    wire [15:0] scale_nxt = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : scale_ff[15:8],
                             avs_byteenable_i[0] ? avs_writedata_i[7:0] : scale_ff[7:0]};

    // ****************************************
    // loop mode commands
    // ****************************************
    wire cmd_dual = wr_command & (cmd_code == CMD_DUAL_LOOP_ENABLE);
    wire cmd_single = wr_command & (cmd_code == CMD_SINGLE_LOOP_RESTORE);
    wire cmd_ser_set = wr_command & (cmd_code == CMD_SERIAL_SRC_SET);
    wire cmd_ser_clr = wr_command & (cmd_code == CMD_SERIAL_SRC_CLEAR);

    // source is fixed when dual loop is entered; later source changes wait
    always_comb begin
        nxt_loop = loop_ff;
        case (loop_ff)
            LOOP_SINGLE: begin
                if (cmd_dual & serial_src_ff) begin
                    nxt_loop = LOOP_DUAL_SERIAL; // RULE17
                end else if (cmd_dual & configured_ff) begin
                    nxt_loop = LOOP_DUAL_PULSE; // RULE15
                end
            end
            LOOP_DUAL_PULSE: begin
                if (cmd_single) begin
                    nxt_loop = LOOP_SINGLE; // RULE16
                end
            end
            LOOP_DUAL_SERIAL: begin
                if (cmd_single) begin
                    nxt_loop = LOOP_SINGLE; // RULE16
                end
            end
            default: begin
                nxt_loop = LOOP_SINGLE;
            end
        endcase
    end

    // ****************************************
    // sample period arithmetic
    // ****************************************
    wire sample_now = (tmr_ff == TMR_LAST); // RULE1
    wire signed [15:0] delta = cnt_up ? RAW_ONE : (cnt_dn ? -RAW_ONE : RAW_ZERO);
    // this cycle's edge is folded in, so an edge on the sample cycle is kept
    wire signed [15:0] raw_now = raw_ff + delta; // RULE1
    wire signed [32:0] prod = raw_now * $signed({1'b0, scale_ff}); // RULE2
    wire signed [39:0] total = 40'(prod) + 40'($signed({excess_ff, FRAC_ZERO}))
                               + 40'($signed({1'b0, frac_ff})); // RULE2 RULE3 RULE4
    wire signed [31:0] whole = total[39:SCALE_FRAC_BITS];
    wire signed [31:0] applied = sed_clamp(whole); // RULE4
    wire signed [31:0] excess_full = whole - applied; // RULE4
    wire index_rise = enc_index_i & ~index_prev_ff; // RULE11

    // ****************************************
    // timer and period counter
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tmr_ff <= TMR_ZERO;
            raw_ff <= RAW_ZERO;
            sample_ff <= 1'b0;
        end else begin
            tmr_ff <= sample_now ? TMR_ZERO : tmr_ff + TMR_ONE; // RULE1
            raw_ff <= sample_now ? RAW_ZERO : raw_now; // RULE1
            sample_ff <= sample_now;
        end
    end

    // position, fraction and excess update once per period
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            frac_ff <= FRAC_ZERO;
            excess_ff <= EXCESS_ZERO;
            ext_pos_ff <= WORD_ZERO;
        end else if (sample_now) begin
            frac_ff <= total[SCALE_FRAC_BITS-1:0]; // RULE3
            excess_ff <= excess_full[23:0]; // RULE4
            ext_pos_ff <= ext_pos_ff + applied; // RULE2
        end
    end

    // ****************************************
    // index capture
    // ****************************************
    // a new index wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            index_prev_ff <= 1'b0;
            index_flag_ff <= 1'b0;
            index_pos_ff <= WORD_ZERO;
        end else begin
            index_prev_ff <= enc_index_i;
            index_flag_ff <= index_rise | (index_flag_ff
                             & ~(wr_status & avs_writedata_i[ST_INDEX])); // RULE11
            if (index_rise) begin
                index_pos_ff <= ext_pos_ff; // RULE11
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fmt_ff <= FMT_STEP_DIR;
            configured_ff <= 1'b0;
            serial_src_ff <= 1'b0;
            scale_ff <= SCALE_RESET;
            loop_ff <= LOOP_SINGLE;
        end else begin
            if (wr_format & fmt_legal) begin
                fmt_ff <= sed_fmt_type'(fmt_req); // RULE12
                configured_ff <= 1'b1; // RULE15
            end
            if (cmd_ser_set) begin
                serial_src_ff <= 1'b1; // RULE17
            end else if (cmd_ser_clr) begin
                serial_src_ff <= 1'b0;
            end
            if (wr_scale) begin
                scale_ff <= scale_nxt;
            end
            loop_ff <= nxt_loop;
        end
    end

    // ****************************************
    // loop outputs
    // ****************************************
    wire dual_pulse = (loop_ff == LOOP_DUAL_PULSE);
    wire dual_serial = (loop_ff == LOOP_DUAL_SERIAL);
    wire [31:0] loop_sel = dual_pulse ? ext_pos_ff
                         : (dual_serial ? serial_pos_i : int_pos_i); // RULE13 RULE17
    // pulse input commands motion unless it is the feedback source
    wire cmd_free = ~dual_pulse; // RULE18

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            loop_pos_ff <= WORD_ZERO;
            commut_pos_ff <= WORD_ZERO;
            est_pos_ff <= WORD_ZERO;
        end else begin
            loop_pos_ff <= loop_sel; // RULE13
            commut_pos_ff <= int_pos_i; // RULE14
            est_pos_ff <= int_pos_i; // RULE14
        end
    end

    assign loop_pos_o = loop_pos_ff;
    assign commut_pos_o = commut_pos_ff;
    assign est_pos_o = est_pos_ff;
    assign motion_cmd_pos_o = ext_pos_ff;
    assign motion_cmd_en_o = cmd_free; // RULE18
    assign sample_tick_o = sample_ff;

    // ****************************************
    // read data
    // ****************************************
    wire [31:0] status_word = {26'h0000000, THREE_FORMATS, (excess_ff != EXCESS_ZERO),
                               index_flag_ff, serial_src_ff, (dual_pulse | dual_serial),
                               configured_ff};
    wire [31:0] read_mux = (avs_address_i == ADDR_FORMAT) ? {30'h00000000, fmt_ff}
                         : (avs_address_i == ADDR_SCALE) ? {16'h0000, scale_ff}
                         : (avs_address_i == ADDR_STATUS) ? status_word
                         : (avs_address_i == ADDR_POSITION) ? ext_pos_ff
                         : (avs_address_i == ADDR_EXCESS) ? 32'($signed(excess_ff))
                         : (avs_address_i == ADDR_INDEX_POS) ? index_pos_ff
                         : (avs_address_i == ADDR_FEEDBACK) ? loop_pos_ff
                         : WORD_ZERO;

    // read data is captured in the wait cycle and holds through the accept edge
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= WORD_ZERO;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (avs_read_i & ~ack_ff) begin
                rdata_ff <= read_mux;
            end
        end
    end

    assign avs_readdata_o = rdata_ff;

endmodule

// *** design/sed_pkg.sv ***
// constants, encodings and register map of the secondary encoder input decoder
// assumes a 10 MHz system clock and an Avalon-MM register slave with 32-bit data
package sed_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SAMPLE_PERIOD_US = 120;
    // least time, rounded up to whole cycles
    localparam int unsigned SAMPLE_CYCLES =
        (SAMPLE_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 11;
    localparam logic [TMR_W-1:0] TMR_ZERO = 11'h000;
    localparam logic [TMR_W-1:0] TMR_ONE = 11'h001;
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SAMPLE_CYCLES - 1);

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_FORMAT = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_SCALE = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_POSITION = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_EXCESS = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_INDEX_POS = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_FEEDBACK = 5'h1C;

    // command codes written to the low byte of the command register
    localparam logic [7:0] CMD_DUAL_LOOP_ENABLE = 8'h01;
    localparam logic [7:0] CMD_SINGLE_LOOP_RESTORE = 8'h02;
    localparam logic [7:0] CMD_SERIAL_SRC_SET = 8'h03;
    localparam logic [7:0] CMD_SERIAL_SRC_CLEAR = 8'h04;

    // status bit positions
    localparam int ST_CONFIGURED = 0;
    localparam int ST_DUAL = 1;
    localparam int ST_SERIAL_SRC = 2;
    localparam int ST_INDEX = 3;
    localparam int ST_EXCESS_NZ = 4;
    localparam int ST_THREE_FMT = 5;

    // ****************************************
    // scaling and limits
    // ****************************************
    localparam int SCALE_FRAC_BITS = 8;
    localparam logic [15:0] SCALE_RESET = 16'h0100;
    localparam logic [7:0] FRAC_ZERO = 8'h00;
    localparam logic signed [31:0] APPLY_MAX = 32'sh0000001F;
    localparam logic signed [31:0] APPLY_MIN = -32'sh00000020;
    localparam logic signed [15:0] RAW_ZERO = 16'sh0000;
    localparam logic signed [15:0] RAW_ONE = 16'sh0001;
    localparam logic signed [23:0] EXCESS_ZERO = 24'sh000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        FMT_STEP_DIR = 2'b00,
        FMT_UP_DOWN = 2'b01,
        FMT_QUAD = 2'b11
    } sed_fmt_type;

    typedef enum logic [1:0] {
        LOOP_SINGLE = 2'b00,
        LOOP_DUAL_PULSE = 2'b01,
        LOOP_DUAL_SERIAL = 2'b11
    } sed_loop_type;

endpackage

// *** design/sed_edge_decoder.sv ***
// edge decoder: turns step/direction, step up/down or quadrature into count pulses
// assumes inputs are already synchronous to sys_clk_i
`timescale 1ns/1ns
module sed_edge_decoder (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire sed_pkg::sed_fmt_type fmt_i,
    input wire logic ch_a_i,
    input wire logic ch_b_i,
    output logic cnt_up_o,
    output logic cnt_dn_o
);
    import sed_pkg::*;

    logic a_prev_ff;
    logic b_prev_ff;

    // ****************************************
    // previous levels
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            a_prev_ff <= 1'b0;
            b_prev_ff <= 1'b0;
        end else begin
            a_prev_ff <= ch_a_i;
            b_prev_ff <= ch_b_i;
        end
    end

    // edge terms shared by the formats
    wire a_rise = ch_a_i & ~a_prev_ff;
    wire b_rise = ch_b_i & ~b_prev_ff;
    wire a_chg = ch_a_i ^ a_prev_ff;
    wire b_chg = ch_b_i ^ b_prev_ff;
    // both channels moving at once cannot be resolved, so it counts nothing
    wire quad_ok = a_chg ^ b_chg; // RULE19
    wire quad_up = ch_a_i ^ b_prev_ff; // RULE10 RULE19
    // step and direction: one count per step rising edge
    wire sd_up = a_rise & ch_b_i; // RULE6 RULE7
    wire sd_dn = a_rise & ~ch_b_i; // RULE6 RULE7
    // up/down: simultaneous pulses cancel
    wire ud_up = a_rise & ~b_rise; // RULE8
    wire ud_dn = b_rise & ~a_rise; // RULE8
    // quadrature counts each edge of either channel that comes alone, none when both change
    wire qd_up = quad_ok & quad_up; // RULE9
    wire qd_dn = quad_ok & ~quad_up; // RULE9

    // format selection
    assign cnt_up_o = (fmt_i == FMT_QUAD) ? qd_up : (fmt_i == FMT_UP_DOWN) ? ud_up : sd_up;
    assign cnt_dn_o = (fmt_i == FMT_QUAD) ? qd_dn : (fmt_i == FMT_UP_DOWN) ? ud_dn : sd_dn;

endmodule

// *** dv/sed_assertions.sv ***
// port checker for the secondary encoder input decoder
// assumes it is bound to sed_top and sees only its ports
`timescale 1ns/1ns
module sed_assertions (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic [31:0] int_pos_i,
    input wire logic [31:0] commut_pos_o,
    input wire logic [31:0] est_pos_o,
    input wire logic [31:0] motion_cmd_pos_o,
    input wire logic motion_cmd_en_o,
    input wire logic sample_tick_o
);
    import sed_pkg::*;
    logic [10:0] gap_ff;
    logic seen_ff;
    logic [31:0] prev_ff;
    logic signed [31:0] dpos;
    // ****************************************
    // helper logic
    // ****************************************
    // cycles since the last tick; the first tick has no reference, so it is skipped
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || sample_tick_o) begin
            gap_ff <= 11'h000;
        end else begin
            gap_ff <= gap_ff + 11'h001;
        end
    end
    // tick seen flag and last position
    always_ff @(posedge sys_clk_i) begin
        seen_ff <= !sys_rst_i && (seen_ff || sample_tick_o);
        prev_ff <= motion_cmd_pos_o;
    end
    // per-sample step of the external count
    assign dpos = $signed(motion_cmd_pos_o - prev_ff);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_sample_period: assert property (sample_tick_o && seen_ff |-> gap_ff == 11'h4AF)
        else $error("sample tick spacing wrong");
    a_tick_single: assert property (sample_tick_o |=> !sample_tick_o)
        else $error("sample tick longer than one cycle");
    a_pos_hold: assert property ($changed(motion_cmd_pos_o) |-> sample_tick_o || $past(sample_tick_o))
        else $error("position moved between samples");
    a_apply_clamp: assert property ($changed(motion_cmd_pos_o) |-> dpos <= APPLY_MAX && dpos >= APPLY_MIN)
        else $error("applied counts outside limit");
    a_commut_int: assert property (!$past(sys_rst_i) |-> commut_pos_o == $past(int_pos_i))
        else $error("commutation position not internal");
    a_est_int: assert property (!$past(sys_rst_i) |-> est_pos_o == $past(int_pos_i))
        else $error("estimation position not internal");
    a_reset_single: assert property ($past(sys_rst_i) |-> motion_cmd_en_o && !sample_tick_o && motion_cmd_pos_o == 32'h0)
        else $error("state after reset wrong");
    a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");
endmodule
bind sed_top sed_assertions u_sed_assertions (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .int_pos_i(int_pos_i), .commut_pos_o(commut_pos_o), .est_pos_o(est_pos_o),
    .motion_cmd_pos_o(motion_cmd_pos_o), .motion_cmd_en_o(motion_cmd_en_o),
    .sample_tick_o(sample_tick_o));

// *** dv/sed_enc_src.sv ***
// external encoder or step source model driving the decoder's pin inputs
// assumes callers invoke its tasks from one process, just after a clock edge
`timescale 1ns/1ns
module sed_enc_src (
    input wire logic sys_clk_i,
    output logic enc_a_o,
    output logic enc_b_o,
    output logic enc_index_o
);
    // lines idle low at time zero
    initial begin
        enc_a_o = 1'b0;
        enc_b_o = 1'b0;
        enc_index_o = 1'b0;
    end
    // one level change per edge keeps the count rate inside the decoder's reach
    task automatic set(input logic a, input logic b);
        @(posedge sys_clk_i);
        enc_a_o <= a;
        enc_b_o <= b;
    endtask
    // direction level stands with the step rise
    task automatic step(input logic dir);
        set(1'b1, dir);
        set(1'b0, dir);
    endtask
    // one index pulse
    task automatic index();
        @(posedge sys_clk_i);
        enc_index_o <= 1'b1;
        @(posedge sys_clk_i);
        enc_index_o <= 1'b0;
    endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the secondary encoder input decoder
// assumes the design files and the encoder source model are compiled first
`timescale 1ns/1ns
module tb;
    import sed_pkg::*;
    localparam logic [31:0] INT_POS = 32'h00001234;
    localparam logic [31:0] SER_POS = 32'h00ABCDEF;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o, loop_pos_o, commut_pos_o, est_pos_o, motion_cmd_pos_o;
    logic avs_waitrequest_o, motion_cmd_en_o, sample_tick_o, enc_a, enc_b, enc_idx;
    logic [31:0] exp_pos = 32'h0;
    logic [31:0] int_pos = INT_POS;
    logic [31:0] ser_pos = SER_POS;
    int num_errors = 0;
    int n_checks = 0;
    int i;
    // ****************************************
    // clock and instances
    // ****************************************
    always #50 sys_clk_i = ~sys_clk_i;
    sed_top u_sed_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_index_i(enc_idx), .int_pos_i(int_pos),
        .serial_pos_i(ser_pos), .loop_pos_o(loop_pos_o), .commut_pos_o(commut_pos_o),
        .est_pos_o(est_pos_o), .motion_cmd_pos_o(motion_cmd_pos_o),
        .motion_cmd_en_o(motion_cmd_en_o), .sample_tick_o(sample_tick_o));
    sed_enc_src u_sed_enc_src (.sys_clk_i(sys_clk_i), .enc_a_o(enc_a), .enc_b_o(enc_b),
        .enc_index_o(enc_idx));
    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one bus access; an edge passes first so a strobe is never set twice in a step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    // bounded wait for the next sample tick
    task automatic wait_tick();
        int n;
        for (n = 0; n < 1300; n++) begin
            @(posedge sys_clk_i);
            if (sample_tick_o === 1'b1) begin
                return;
            end
        end
        num_errors++;
        end_sim();
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(ADDR_STATUS, 32'h20);
        rd_chk(ADDR_SCALE, 32'h100);
        rd_chk(5'h02, 32'h0);
        wr(ADDR_COMMAND, 32'h1);
        rd_chk(ADDR_STATUS, 32'h20);
        wr(ADDR_FORMAT, 32'h2);
        rd_chk(ADDR_FORMAT, 32'h0);
        // step and direction, both directions
        wr(ADDR_FORMAT, 32'h0);
        repeat (5) u_sed_enc_src.step(1'b1);
        repeat (2) u_sed_enc_src.step(1'b0);
        exp_pos += 3;
        repeat (2) wait_tick();
        rd_chk(ADDR_POSITION, exp_pos);
        // step up and step down
        wr(ADDR_FORMAT, 32'h1);
        for (i = 0; i < 5; i++) begin
            u_sed_enc_src.set(i < 4, i == 4);
            u_sed_enc_src.set(1'b0, 1'b0);
        end
        exp_pos += 3;
        repeat (2) wait_tick();
        rd_chk(ADDR_POSITION, exp_pos);
        // quadrature: A leads twice, B leads once, then two double changes
        wr(ADDR_FORMAT, 32'h3);
        repeat (2) begin
            u_sed_enc_src.set(1'b1, 1'b0);
            u_sed_enc_src.set(1'b1, 1'b1);
            u_sed_enc_src.set(1'b0, 1'b1);
            u_sed_enc_src.set(1'b0, 1'b0);
        end
        u_sed_enc_src.set(1'b0, 1'b1);
        u_sed_enc_src.set(1'b1, 1'b1);
        u_sed_enc_src.set(1'b1, 1'b0);
        u_sed_enc_src.set(1'b0, 1'b0);
        u_sed_enc_src.set(1'b1, 1'b1);
        u_sed_enc_src.set(1'b0, 1'b0);
        exp_pos += 4;
        repeat (2) wait_tick();
        rd_chk(ADDR_POSITION, exp_pos);
        rd_chk(ADDR_FORMAT, 32'h3);
        // half scale: the fraction carries into the next period
        wr(ADDR_FORMAT, 32'h0);
        wr(ADDR_SCALE, 32'h80);
        wait_tick();
        repeat (3) u_sed_enc_src.step(1'b1);
        wait_tick();
        exp_pos += 1;
        rd_chk(ADDR_POSITION, exp_pos);
        u_sed_enc_src.step(1'b1);
        wait_tick();
        exp_pos += 1;
        rd_chk(ADDR_POSITION, exp_pos);
        wr(ADDR_SCALE, 32'h100);
        // burst beyond the per-sample limit
        wait_tick();
        repeat (40) u_sed_enc_src.step(1'b1);
        wait_tick();
        exp_pos += 31;
        rd_chk(ADDR_POSITION, exp_pos);
        rd_chk(ADDR_EXCESS, 32'h9);
        rd_chk(ADDR_STATUS, 32'h31);
        wait_tick();
        exp_pos += 9;
        rd_chk(ADDR_POSITION, exp_pos);
        rd_chk(ADDR_EXCESS, 32'h0);
        // index capture and clear
        u_sed_enc_src.index();
        rd_chk(ADDR_STATUS, 32'h29);
        rd_chk(ADDR_INDEX_POS, exp_pos);
        wr(ADDR_STATUS, 32'h8);
        rd_chk(ADDR_STATUS, 32'h21);
        // dual loop from pulses, back to single, then from the serial source
        wr(ADDR_COMMAND, 32'h1);
        rd_chk(ADDR_STATUS, 32'h23);
        rd_chk(ADDR_FEEDBACK, exp_pos);
        chk("motion_cmd_en", {31'h0, motion_cmd_en_o}, 32'h0);
        chk("commut_pos", commut_pos_o, INT_POS);
        wr(ADDR_COMMAND, 32'h2);
        rd_chk(ADDR_STATUS, 32'h21);
        rd_chk(ADDR_FEEDBACK, INT_POS);
        wr(ADDR_COMMAND, 32'h3);
        wr(ADDR_COMMAND, 32'h1);
        rd_chk(ADDR_STATUS, 32'h27);
        rd_chk(ADDR_FEEDBACK, SER_POS);
        chk("motion_cmd_en", {31'h0, motion_cmd_en_o}, 32'h1);
        repeat (2) u_sed_enc_src.step(1'b1);
        exp_pos += 2;
        repeat (2) wait_tick();
        chk("motion_cmd_pos", motion_cmd_pos_o, exp_pos);
        wr(ADDR_COMMAND, 32'h2);
        // internal position moves; single loop and estimation must follow it
        int_pos <= ~INT_POS;
        wr(ADDR_COMMAND, 32'h4);
        rd_chk(ADDR_FEEDBACK, ~INT_POS);
        chk("loop_pos", loop_pos_o, ~INT_POS);
        chk("est_pos", est_pos_o, ~INT_POS);
        // serial source cleared, so dual enable now picks the pulse count
        wr(ADDR_COMMAND, 32'h1);
        rd_chk(ADDR_STATUS, 32'h23);
        end_sim();
    end
endmodule
